// ==== inc/panel_pkg.sv ====
// Constants and types shared by the voice assignment and panel controller.
// Assumes one 10 MHz system clock; no software-visible registers.
//
// How it works
// R01: At power-on, light track lamps one by one, showing 1 to 6 on display.
// R02: Power-on tuning lasts about twenty seconds before the device is ready.
// R03: During tuning, ignore keys and keep the song recorder inoperative.
// R04: After tuning show 00 and make sound 00 the current selection.
// R05: When ready, light the first-song and halted-transport lamps.
// R06: Record held plus track-volume switch slowly lowers or raises master pitch.
// R07: In live play all six voices use the one selected sound.
// R08: Track lamps show which voices are sounding during live play.
// R09: At most six keys sound; only the six latest pressed keep voices.
// R10: A new key takes the least recently used voice.
// R11: A repeated key is reassigned to the voice it had before.
// R12: First keypad digit shows in the left place; sound not changed yet.
// R13: Second keypad digit immediately switches the sound to the entered number.
// R14: Eighty fixed sounds; entries 80 to 99 ignored unless loaded externally.
// R15: Transpose held plus key sets transposition above C; C cancels it.
// R16: Keep an LRU order of voices, updated on assignment, not on release.
package panel_pkg;
    localparam int unsigned VOICES       = 6;
    localparam int unsigned KEY_W        = 7;
    localparam int unsigned SOUND_W      = 7;
    localparam int unsigned PITCH_W      = 8;
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TUNE_S       = 20;
    localparam longint unsigned TUNE_CYC = longint'(TUNE_S) * CLK_HZ;
    localparam int unsigned PITCH_STEP_MS = 100;
    localparam int unsigned PITCH_CYC    = PITCH_STEP_MS * (CLK_HZ / 1000);
    localparam logic [SOUND_W-1:0] FIXED_SOUNDS = 7'h50;
    localparam logic [SOUND_W-1:0] FIRST_SOUND  = 7'h00;
    localparam logic [PITCH_W-1:0] PITCH_MID    = 8'h80;
    localparam logic [3:0] OCTAVE = 4'hC;
    localparam logic [3:0] BLANK_DIGIT = 4'hF;
    typedef enum logic [1:0] {ST_TUNE, ST_READY} mode_e;
endpackage : panel_pkg

// ==== rtl/voice_lru.sv ====
// Six-voice allocator: last-note priority with least recently used stealing.
// Assumes key events are single-cycle pulses on the system clock.
`timescale 1ns/1ns
module voice_lru #(
    parameter int unsigned N = panel_pkg::VOICES
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    // Key events
    input  wire logic                          key_on,
    input  wire logic                          key_off,
    input  wire logic [panel_pkg::KEY_W-1:0]   key_num,
    // Voice state
    output logic      [N-1:0]                  gate,
    output logic      [N*panel_pkg::KEY_W-1:0] voice_key
);
    import panel_pkg::*;
    localparam int unsigned AW = $clog2(N);
    initial begin
        if (N < 2 || N > 16) $error("voice_lru: N out of range");
    end
    logic [AW-1:0]    age   [N];
    logic [N-1:0]     hit;
    logic [AW-1:0]    pick;
    logic [AW-1:0]    pick_age;
    logic             found;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_hit
            assign hit[g] = voice_key[g*KEY_W +: KEY_W] == key_num;
        end
    endgenerate
    always_comb begin
        found    = 1'b0;
        pick     = '0;
        pick_age = '0;
        for (int i = 0; i < N; i++) begin
            if (hit[i] && !found) begin // R11
                found    = 1'b1;
                pick     = AW'(i);
                pick_age = age[i];
            end
        end
        if (!found) begin
            for (int i = 0; i < N; i++) begin
                if (age[i] == AW'(N - 1)) begin // R10
                    pick     = AW'(i);
                    pick_age = age[i];
                end
            end
        end
    end
    // Age 0 is newest; the voice picked becomes newest and younger ones age by one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                age[i] <= AW'(i);
            end
        end else if (key_on) begin
            for (int i = 0; i < N; i++) begin
                if (AW'(i) == pick) begin
                    age[i] <= '0; // R16
                end else if (age[i] < pick_age) begin
                    age[i] <= age[i] + 1'b1; // R16
                end
            end
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gate      <= '0;
            voice_key <= '0;
        end else if (key_on) begin
            gate[pick]                     <= 1'b1; // R09
            voice_key[pick*KEY_W +: KEY_W] <= key_num;
        end else if (key_off) begin
            // Release frees the voice but leaves the age order alone
            for (int i = 0; i < N; i++) begin
                if (hit[i]) begin
                    gate[i] <= 1'b0; // R16
                end
            end
        end
    end
endmodule : voice_lru

// ==== rtl/voice_assign_panel_ctrl.sv ====
// Front-panel and voice-assignment controller top level.
// Assumes panel switches and keys arrive asynchronously; key events are
// given as a pulse pair plus key number that is stable while the pulse is high.
`timescale 1ns/1ns
module voice_assign_panel_ctrl #(
    parameter longint unsigned TUNE_CYCLES  = panel_pkg::TUNE_CYC,
    parameter int unsigned     PITCH_CYCLES = panel_pkg::PITCH_CYC
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            nrst,
    // Keyboard
    input  wire logic                            key_down,
    input  wire logic                            key_up,
    input  wire logic [panel_pkg::KEY_W-1:0]     key_code,
    // Panel switches
    input  wire logic                            keypad_strobe,
    input  wire logic [3:0]                      keypad_digit,
    input  wire logic                            record_sw,
    input  wire logic                            vol_down_sw,
    input  wire logic                            vol_up_sw,
    input  wire logic                            transpose_sw,
    // External loading of the upper sound locations
    input  wire logic                            ext_loaded,
    // Display and lamps
    output logic      [3:0]                      disp_left,
    output logic      [3:0]                      disp_right,
    output logic      [panel_pkg::VOICES-1:0]    track_lamp,
    output logic                                 song1_lamp,
    output logic                                 stop_lamp,
    output logic                                 ready,
    output logic                                 recorder_enable,
    // Voice side
    output logic      [panel_pkg::VOICES-1:0]    voice_gate,
    output logic      [panel_pkg::VOICES*panel_pkg::KEY_W-1:0] voice_key,
    output logic      [panel_pkg::SOUND_W-1:0]   voice_sound,
    output logic      [3:0]                      transpose,
    output logic      [panel_pkg::PITCH_W-1:0]   master_pitch
);
    import panel_pkg::*;
    localparam int unsigned TW = 36;
    localparam int unsigned PW = 24;
    initial begin
        if (TUNE_CYCLES < 6 || TUNE_CYCLES >= (64'h1 << TW))
            $error("TUNE_CYCLES out of range");
        if (PITCH_CYCLES < 1 || PITCH_CYCLES >= (1 << PW))
            $error("PITCH_CYCLES out of range");
    end
    localparam logic [TW-1:0] TUNE_N  = TW'(TUNE_CYCLES);
    localparam logic [TW-1:0] PHASE_N = TW'(TUNE_CYCLES / VOICES);
    localparam logic [PW-1:0] PITCH_N = PW'(PITCH_CYCLES);

    // Two-stage synchronisers for everything from outside the clock domain
    localparam int unsigned SW = 12 + KEY_W;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {key_down, key_up, keypad_strobe, keypad_digit, record_sw,
                       vol_down_sw, vol_up_sw, transpose_sw, ext_loaded, key_code};
            sync_b <= sync_a;
        end
    end
    logic             s_down;
    logic             s_up;
    logic             s_pad;
    logic [3:0]       s_digit;
    logic             s_rec;
    logic             s_vdn;
    logic             s_vup;
    logic             s_trn;
    logic             s_load;
    logic [KEY_W-1:0] s_key;
    assign {s_down, s_up, s_pad, s_digit, s_rec, s_vdn, s_vup, s_trn, s_load, s_key} = sync_b;

    // Edge detect on the synchronised strobes
    logic d_down;
    logic d_up;
    logic d_pad;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            d_down <= 1'b0;
            d_up   <= 1'b0;
            d_pad  <= 1'b0;
        end else begin
            d_down <= s_down;
            d_up   <= s_up;
            d_pad  <= s_pad;
        end
    end
    logic down_ev;
    logic up_ev;
    logic pad_ev;
    assign down_ev = s_down & ~d_down;
    assign up_ev   = s_up & ~d_up;
    assign pad_ev  = s_pad & ~d_pad;

    // Power-on tuning sequence
    mode_e          mode;
    logic [TW-1:0]  tune_cnt;
    logic [TW-1:0]  phase_cnt;
    logic [2:0]     phase;
    logic           tune_done;
    assign tune_done = tune_cnt == TUNE_N - 1'b1;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode      <= ST_TUNE;
            tune_cnt  <= '0;
            phase_cnt <= '0;
            phase     <= '0;
        end else begin
            case (mode)
                ST_TUNE: begin
                    tune_cnt <= tune_cnt + 1'b1; // R02
                    if (phase_cnt == PHASE_N - 1'b1) begin
                        phase_cnt <= '0;
                        if (phase != 3'(VOICES - 1)) begin
                            phase <= phase + 1'b1; // R01
                        end
                    end else begin
                        phase_cnt <= phase_cnt + 1'b1;
                    end
                    if (tune_done) begin
                        mode <= ST_READY; // R02
                    end
                end
                ST_READY: mode <= ST_READY;
                default:  mode <= ST_TUNE;
            endcase
        end
    end
    logic is_ready;
    assign is_ready = mode == ST_READY;

    // Key events reach the allocator only once ready; transpose held steals the key
    logic alloc_on;
    logic alloc_off;
    assign alloc_on  = down_ev & is_ready & ~s_trn; // R03
    assign alloc_off = up_ev & is_ready;            // R03
    logic [VOICES-1:0]       lru_gate;
    logic [VOICES*KEY_W-1:0] lru_key;
    voice_lru #(
        .N (VOICES)
    ) u_lru (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .key_on    (alloc_on),
        .key_off   (alloc_off),
        .key_num   (s_key),
        .gate      (lru_gate),
        .voice_key (lru_key)
    );

    // Keypad two-digit entry
    logic             first_held;
    logic [3:0]       first_digit;
    logic [SOUND_W-1:0] sound;
    logic [SOUND_W-1:0] entered;
    logic             entry_ok;
    // Widen before the product so the tens digit cannot wrap at four bits
    assign entered  = SOUND_W'(first_digit) * SOUND_W'(4'hA) + SOUND_W'(s_digit);
    assign entry_ok = entered < FIXED_SOUNDS || s_load;
    // Digits above 9 are not keys; they are dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            first_held  <= 1'b0;
            first_digit <= '0;
            sound       <= FIRST_SOUND;
        end else if (is_ready && pad_ev && s_digit <= 4'h9) begin
            if (!first_held) begin
                if (s_digit < 4'h8 || s_load) begin // R14
                    first_held  <= 1'b1; // R12
                    first_digit <= s_digit;
                end
            end else if (entry_ok) begin // R14
                first_held <= 1'b0;
                sound      <= entered; // R13
            end
        end
    end

    // Transposition set by a key while transpose is held
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            transpose <= '0;
        end else if (is_ready && s_trn && down_ev) begin
            transpose <= 4'(s_key % OCTAVE); // R15
        end
    end

    // Master pitch: slow steps while record and a volume switch are held
    logic [PW-1:0] pitch_cnt;
    logic          pitch_tick;
    logic          pitch_req;
    assign pitch_req  = is_ready & s_rec & (s_vdn ^ s_vup);
    assign pitch_tick = pitch_cnt == PITCH_N - 1'b1;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pitch_cnt <= '0;
        end else if (!pitch_req || pitch_tick) begin
            pitch_cnt <= '0;
        end else begin
            pitch_cnt <= pitch_cnt + 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            master_pitch <= PITCH_MID;
        end else if (pitch_req && pitch_tick) begin
            if (s_vup && master_pitch != '1) begin
                master_pitch <= master_pitch + 1'b1; // R06
            end else if (s_vdn && master_pitch != '0) begin
                master_pitch <= master_pitch - 1'b1; // R06
            end
        end
    end

    // Display, lamps and voice outputs
    logic [3:0] tens;
    logic [3:0] ones;
    assign tens = 4'(sound / SOUND_W'(4'hA));
    assign ones = 4'(sound % SOUND_W'(4'hA));
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            disp_left  <= BLANK_DIGIT;
            disp_right <= 4'h1;
            track_lamp <= '0;
        end else if (!is_ready) begin
            disp_left  <= BLANK_DIGIT;
            disp_right <= 4'(phase) + 4'h1; // R01
            track_lamp <= VOICES'(1) << phase; // R01
        end else begin
            disp_left  <= first_held ? first_digit : tens; // R04 R12
            disp_right <= first_held ? BLANK_DIGIT : ones;
            track_lamp <= lru_gate; // R08
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            song1_lamp      <= 1'b0;
            stop_lamp       <= 1'b0;
            ready           <= 1'b0;
            recorder_enable <= 1'b0;
            voice_gate      <= '0;
            voice_key       <= '0;
            voice_sound     <= FIRST_SOUND;
        end else begin
            song1_lamp      <= is_ready; // R05
            stop_lamp       <= is_ready; // R05
            ready           <= is_ready;
            recorder_enable <= is_ready; // R03
            voice_gate      <= lru_gate; // R09
            voice_key       <= lru_key;
            voice_sound     <= sound; // R07 R04
        end
    end
endmodule : voice_assign_panel_ctrl

// ==== tb/panel_chk.sv ====
// Port-level checker for the panel and voice controller, bound to its top module.
// Assumes a single sys_clk domain and the asynchronous active-low nrst.
`timescale 1ns/1ns
module panel_chk
    import panel_pkg::*;
#(
    parameter longint unsigned TUNE_CYCLES  = panel_pkg::TUNE_CYC,
    parameter int unsigned     PITCH_CYCLES = panel_pkg::PITCH_CYC
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    // Switches
    input wire logic                  record_sw,
    input wire logic                  ext_loaded,
    // Outputs watched
    input wire logic [3:0]            disp_left,
    input wire logic [3:0]            disp_right,
    input wire logic [VOICES-1:0]     track_lamp,
    input wire logic                  song1_lamp,
    input wire logic                  stop_lamp,
    input wire logic                  ready,
    input wire logic                  recorder_enable,
    input wire logic [VOICES-1:0]     voice_gate,
    input wire logic [SOUND_W-1:0]    voice_sound,
    input wire logic [3:0]            transpose,
    input wire logic [PITCH_W-1:0]    master_pitch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Cycles since reset release, frozen once ready
    int unsigned tune_cnt;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) tune_cnt <= 0;
        else if (!ready) tune_cnt <= tune_cnt + 1;
    end
    ready_time_a: assert property ($rose(ready) |-> tune_cnt + 2 >= TUNE_CYCLES && tune_cnt <= TUNE_CYCLES + 3) else $error("ready at wrong time");
    tune_lamps_a: assert property (!ready |-> $onehot0(track_lamp)) else $error("tuning lamps not one-hot");
    tune_silent_a: assert property (!ready |-> voice_gate == '0 && !recorder_enable) else $error("active during tuning");
    ready_show_a: assert property ($rose(ready) |-> disp_left == 4'h0 && disp_right == 4'h0 && voice_sound == FIRST_SOUND) else $error("ready display wrong");
    ready_lamps_a: assert property (ready |-> song1_lamp && stop_lamp && recorder_enable) else $error("ready lamps off");
    live_lamps_a: assert property (ready && $past(ready) |-> track_lamp == voice_gate) else $error("lamps differ from gates");
    pitch_step_a: assert property ($changed(master_pitch) |-> master_pitch == $past(master_pitch) + 8'h01 || master_pitch == $past(master_pitch) - 8'h01) else $error("pitch jumped");
    pitch_hold_a: assert property (!record_sw && !$past(record_sw) && !$past(record_sw, 2) && !$past(record_sw, 3) |-> $stable(master_pitch)) else $error("pitch moved without record");
    sound_range_a: assert property ($changed(voice_sound) |-> ready && (voice_sound < FIXED_SOUNDS || ext_loaded || $past(ext_loaded, 4))) else $error("bad sound change");
    transp_range_a: assert property (transpose < OCTAVE) else $error("transpose out of octave");
    cover property ($rose(ready));
    cover property (voice_gate == 6'h3F);
    cover property ($changed(master_pitch));
    cover property ($changed(voice_sound));
endmodule : panel_chk
bind voice_assign_panel_ctrl panel_chk #(.TUNE_CYCLES(TUNE_CYCLES), .PITCH_CYCLES(PITCH_CYCLES))
    panel_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .record_sw(record_sw),
    .ext_loaded(ext_loaded), .disp_left(disp_left), .disp_right(disp_right),
    .track_lamp(track_lamp), .song1_lamp(song1_lamp), .stop_lamp(stop_lamp), .ready(ready),
    .recorder_enable(recorder_enable), .voice_gate(voice_gate), .voice_sound(voice_sound),
    .transpose(transpose), .master_pitch(master_pitch));

// ==== tb/kbd_model.sv ====
// Player model: strikes keys and keypad digits at falling clock edges.
// Assumes the controller syncs strobes and needs data held 3 cycles past a rise.
`timescale 1ns/1ns
module kbd_model (
    // Clock
    input wire logic        sys_clk,
    // Keyboard
    output logic            key_down,
    output logic            key_up,
    output logic [6:0]      key_code,
    // Keypad
    output logic            keypad_strobe,
    output logic [3:0]      keypad_digit
);
    initial begin
        {key_down, key_up, keypad_strobe} = 3'h0;
        key_code = 7'h00;
        keypad_digit = 4'h0;
    end
    // Data is inverted after its hold time so a stale value is never mistaken for a live one
    task automatic key_event(input logic [6:0] k, input logic up);
        @(negedge sys_clk) key_code = k;
        @(negedge sys_clk) if (up) key_up = 1'b1; else key_down = 1'b1;
        repeat (3) @(negedge sys_clk);
        {key_down, key_up} = 2'h0;
        repeat (3) @(negedge sys_clk);
        key_code = ~k;
        repeat (2) @(negedge sys_clk);
    endtask : key_event
    task automatic press(input logic [6:0] k);
        key_event(k, 1'b0);
    endtask : press
    task automatic release_key(input logic [6:0] k);
        key_event(k, 1'b1);
    endtask : release_key
    task automatic pad(input logic [3:0] d);
        @(negedge sys_clk) keypad_digit = d;
        @(negedge sys_clk) keypad_strobe = 1'b1;
        repeat (3) @(negedge sys_clk);
        keypad_strobe = 1'b0;
        repeat (3) @(negedge sys_clk);
        keypad_digit = ~d;
        repeat (2) @(negedge sys_clk);
    endtask : pad
endmodule : kbd_model

// ==== tb/voice_assign_panel_ctrl_tb_top.sv ====
// Self-checking bench: tuning, voice stealing, keypad entry, transpose, master pitch.
// Assumes small TUNE_CYCLES and PITCH_CYCLES and a fixed-seed LFSR for stimulus.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin miscompares++; $display("unexpected at %0t: %s", $time, msg); end end
module voice_assign_panel_ctrl_tb_top;
    import panel_pkg::*;
    logic sys_clk, nrst, record_sw, vol_down_sw, vol_up_sw, transpose_sw, ext_loaded;
    logic key_down, key_up, keypad_strobe, song1_lamp, stop_lamp, ready, recorder_enable;
    logic [KEY_W-1:0] key_code, base, keys [0:8];
    logic [3:0] keypad_digit, disp_left, disp_right, transpose, d1, d2;
    logic [VOICES-1:0] track_lamp, voice_gate;
    logic [VOICES*KEY_W-1:0] voice_key;
    logic [SOUND_W-1:0] voice_sound, cur;
    logic [PITCH_W-1:0] master_pitch;
    logic [31:0] seed;
    int miscompares, comparisons, cycles, n, v;
    voice_assign_panel_ctrl #(.TUNE_CYCLES(60), .PITCH_CYCLES(4)) voice_assign_panel_ctrl_inst (
        .sys_clk(sys_clk), .nrst(nrst), .key_down(key_down), .key_up(key_up),
        .key_code(key_code), .keypad_strobe(keypad_strobe), .keypad_digit(keypad_digit),
        .record_sw(record_sw), .vol_down_sw(vol_down_sw), .vol_up_sw(vol_up_sw),
        .transpose_sw(transpose_sw), .ext_loaded(ext_loaded), .disp_left(disp_left),
        .disp_right(disp_right), .track_lamp(track_lamp), .song1_lamp(song1_lamp),
        .stop_lamp(stop_lamp), .ready(ready), .recorder_enable(recorder_enable),
        .voice_gate(voice_gate), .voice_key(voice_key), .voice_sound(voice_sound),
        .transpose(transpose), .master_pitch(master_pitch));
    kbd_model kbd_model_inst (.sys_clk(sys_clk), .key_down(key_down), .key_up(key_up),
        .key_code(key_code), .keypad_strobe(keypad_strobe), .keypad_digit(keypad_digit));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic int voice_of(input logic [KEY_W-1:0] k);
        voice_of = -1;
        for (int i = 0; i < VOICES; i++)
            if (voice_gate[i] === 1'b1 && voice_key[KEY_W*i +: KEY_W] === k) voice_of = i;
    endfunction : voice_of
    task automatic entry(input logic [3:0] a, input logic [3:0] b);
        kbd_model_inst.pad(a);
        kbd_model_inst.pad(b);
    endtask : entry
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        {nrst, record_sw, vol_down_sw, vol_up_sw, transpose_sw, ext_loaded} = 6'h00;
        seed = 32'hE1C3104F;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) nrst = 1'b1;
        for (int i = 0; i < VOICES; i++) begin
            for (n = 0; track_lamp !== 6'(1) << i && n < 40; n++) @(negedge sys_clk);
            `CHK(disp_right, 4'(i + 1), "tuning digit")
            if (i == 0) begin
                kbd_model_inst.press(7'h30);
                `CHK({voice_gate, recorder_enable}, 7'h00, "active during tuning")
            end
        end
        for (n = 0; ready !== 1'b1 && n < 80; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        `CHK({disp_left, disp_right, voice_sound}, 15'h0000, "not at sound 00")
        `CHK({song1_lamp, stop_lamp, ready, recorder_enable}, 4'hF, "recorder lamps")
        seed = lfsr_next(seed);
        base = seed[6:0] & 7'h3F;
        for (int i = 0; i < 9; i++) keys[i] = base + 7'(i);
        for (int i = 0; i < VOICES; i++) begin
            kbd_model_inst.press(keys[i]);
            `CHK(voice_of(keys[i]) >= 0, 1'b1, "key not sounding")
        end
        `CHK(track_lamp, 6'h3F, "lamps with six keys")
        v = voice_of(keys[0]);
        kbd_model_inst.press(keys[6]);
        `CHK(voice_of(keys[6]), v, "oldest voice not stolen")
        `CHK(voice_of(keys[0]), -1, "seventh key kept oldest")
        v = voice_of(keys[4]);
        kbd_model_inst.release_key(keys[4]);
        `CHK(voice_of(keys[4]), -1, "released key still on")
        kbd_model_inst.press(keys[4]);
        `CHK(voice_of(keys[4]), v, "repeat took a new voice")
        v = voice_of(keys[1]);
        kbd_model_inst.release_key(keys[1]);
        kbd_model_inst.press(keys[7]);
        `CHK(voice_of(keys[7]), v, "release reordered ages")
        cur = 7'h00;
        for (int i = 0; i < 5; i++) begin
            seed = lfsr_next(seed);
            d1 = {1'b0, seed[2:0]};
            d2 = 4'(seed[7:4] % 4'hA);
            kbd_model_inst.pad(d1);
            `CHK({disp_left, disp_right, voice_sound}, {d1, BLANK_DIGIT, cur}, "first digit")
            kbd_model_inst.pad(d2);
            cur = 7'(d1 * 10 + d2);
            `CHK(voice_sound, cur, "second digit")
        end
        kbd_model_inst.pad(4'h8);
        `CHK({disp_left, voice_sound}, {d1, cur}, "upper location taken")
        entry(4'h7, 4'h9);
        `CHK(voice_sound, 7'h4F, "sound 79")
        ext_loaded = 1'b1;
        entry(4'h8, 4'h5);
        `CHK(voice_sound, 7'h55, "loaded sound 85")
        entry(4'h9, 4'h9);
        `CHK(voice_sound, 7'h63, "loaded sound 99")
        ext_loaded = 1'b0;
        transpose_sw = 1'b1;
        repeat (3) @(negedge sys_clk);
        seed = lfsr_next(seed);
        kbd_model_inst.press(seed[6:0]);
        `CHK(transpose, 4'(seed[6:0] % 12), "transpose interval")
        kbd_model_inst.press(7'h3C);
        `CHK(transpose, 4'h0, "C cancels transpose")
        transpose_sw = 1'b0;
        record_sw = 1'b1;
        vol_up_sw = 1'b1;
        repeat (22) @(negedge sys_clk);
        vol_up_sw = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK(master_pitch >= 8'h82 && master_pitch <= 8'h86, 1'b1, "pitch raise")
        vol_down_sw = 1'b1;
        repeat (44) @(negedge sys_clk);
        vol_down_sw = 1'b0;
        record_sw = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK(master_pitch >= 8'h7A && master_pitch <= 8'h7F, 1'b1, "pitch lower")
        vol_up_sw = 1'b1;
        repeat (20) @(negedge sys_clk);
        `CHK(master_pitch >= 8'h7A && master_pitch <= 8'h7F, 1'b1, "pitch without record")
        vol_up_sw = 1'b0;
        tally_and_finish();
    end
endmodule : voice_assign_panel_ctrl_tb_top
